// ---- design/uhcs_cmd_status.sv ----
// Host command and status register block with APB slave
`timescale 1ns/10ps
module uhcs_cmd_status
   import uhcs_pkg::*;
#(
   parameter int SRST_CYC = UHCS_SRST_CYC // Soft reset length in cycles
)(
   input  wire logic        pclk,          // APB clock, 100 MHz
   input  wire logic        presetn,       // Async reset, active low
   // Register port
   input  wire logic        psel,          // APB select
   input  wire logic        penable,       // APB access phase
   input  wire logic        pwrite,        // APB write
   input  wire logic [11:0] paddr,         // APB byte address
   input  wire logic [31:0] pwdata,        // APB write data
   input  wire logic [3:0]  pstrb,         // APB byte strobes
   output logic      [31:0] prdata,        // APB read data
   output logic             pready,        // APB ready
   output logic             pslverr,       // APB error
   // Frame timing and list walker signals
   input  wire logic        frame_eof,     // End-of-frame point pulse
   input  wire logic        periodic_done, // Periodic list finished
   input  wire logic        ownership_done,// Ownership change taken
   input  wire logic        bulk_head,     // Bulk walker at list head
   input  wire logic        bulk_td,       // Bulk TD detected
   input  wire logic        bulk_end,      // Bulk pass finished
   input  wire logic        ctrl_head,     // Control walker at head
   input  wire logic        ctrl_td,       // Control TD detected
   input  wire logic        ctrl_end,      // Control pass finished
   output logic             bulk_busy,     // Bulk list being processed
   output logic             ctrl_busy,     // Control list processed
   output logic             periodic_overrun, // Overrun pulse
   output logic             ownership_change_event, // Ownership flag
   output logic             soft_reset_active // Soft reset running
);
   // Refuse soft reset lengths the timer cannot serve: below three
   // cycles its countdown would underflow, above the limit the request
   // bit would outlive the longest soft reset the driver may wait for
   if (SRST_CYC < 3 || SRST_CYC > UHCS_SRST_CYC) begin : g_bad_srst
      $error("SRST_CYC out of range");
   end

   // All state lives in one packed struct: one comb process builds the
   // next copy and one flip-flop process stores it, so every bit shares
   // the same asynchronous reset and none can be left out of it
   // Register state of the block
   typedef struct packed {
      logic [1:0] soc;      // Overrun counter
      logic       ownership_change_request;      // Ownership change request
      logic       bulk_list_filled;      // Bulk list filled
      logic       control_list_filled;      // Control list filled
      logic       srst;     // Soft reset request
      logic       ev_so;    // Overrun event flag
      logic       ev_oc;    // Ownership event flag
      logic       per_done; // Periodic list done this frame
      logic       ovr;      // Overrun pulse
      logic [31:0] rdata;   // Read data register
   } uhcs_st_t;

   uhcs_st_t s_r;   // Registered state
   uhcs_st_t s_nxt; // Next state

   // One handshake interface per asynchronous list
   uhcs_list_if bulk_if ();  // Bulk walker link
   uhcs_list_if ctrl_if ();  // Control walker link
   logic        srst_done;   // Soft reset completed
   logic        srst_act;    // Soft reset running
   logic        wr_acc;      // APB write access
   logic        rd_acc;      // APB read access
   logic        hit_cmd;     // Address hits command register
   logic        hit_ev;      // Address hits event register
   logic        hit_lst;     // Address hits list status
   logic [31:0] cmd_view;    // Command register as read
   logic [31:0] ev_view;     // Event register as read
   logic        wr_lo;       // Low byte written
   // The filled bits stay here rather than in the walkers, since
   // software and the walkers may all write them in the same cycle

   // Walker hookups; heads are masked while the soft reset runs so that
   // no list starts on state that is about to be cleared
   assign bulk_if.head     = bulk_head && !srst_act;
   assign bulk_if.td_found = bulk_td;
   assign bulk_if.pass_end = bulk_end;
   assign bulk_if.filled   = s_r.bulk_list_filled;
   assign ctrl_if.head     = ctrl_head && !srst_act;
   assign ctrl_if.td_found = ctrl_td;
   assign ctrl_if.pass_end = ctrl_end;
   assign ctrl_if.filled   = s_r.control_list_filled;

   uhcs_list_walk u_bulk (
      .pclk    (pclk),
      .presetn (presetn),
      .lst     (bulk_if)
   );

   uhcs_list_walk u_ctrl (
      .pclk    (pclk),
      .presetn (presetn),
      .lst     (ctrl_if)
   );

   uhcs_srst_timer #(
      .SRST_CYC (SRST_CYC)
   ) u_srst (
      .pclk    (pclk),
      .presetn (presetn),
      .req     (s_r.srst),
      .active  (srst_act),
      .done    (srst_done)
   );

   // Single-cycle access: ready always, errors on unmapped words.
   // Every transfer is setup plus one access cycle; reads are captured
   // at setup, writes land at the access edge
   assign wr_acc  = psel && penable && pwrite;
   assign rd_acc  = psel && !penable && !pwrite;
   assign wr_lo   = pstrb[0];

   // Address decode on the full byte address; a partial decode would
   // alias unmapped words onto the live registers
   always_comb begin
      // Nothing is hit unless one compare matches
      hit_cmd = 1'b0;
      hit_ev  = 1'b0;
      hit_lst = 1'b0;
      if (paddr == UHCS_CMDSTAT_OFS) begin
         hit_cmd = 1'b1;
      end else if (paddr == UHCS_EVSTAT_OFS) begin
         hit_ev = 1'b1;
      end else if (paddr == UHCS_LISTCTL_OFS) begin
         hit_lst = 1'b1;
      end
   end

   // Read views; reserved bits are zero. Built from registered state
   // only, so a read never disturbs what it reports
   always_comb begin
      cmd_view = UHCS_ZERO;
      cmd_view[UHCS_SOC_HI:UHCS_SOC_LO] = s_r.soc;
      cmd_view[UHCS_OCR_BIT]  = s_r.ownership_change_request;
      cmd_view[UHCS_BLF_BIT]  = s_r.bulk_list_filled;
      cmd_view[UHCS_CLF_BIT]  = s_r.control_list_filled;
      cmd_view[UHCS_SRST_BIT] = s_r.srst;
      // Event view: only the two flags this block owns
      ev_view = UHCS_ZERO;
      ev_view[UHCS_EV_SO_BIT] = s_r.ev_so;
      ev_view[UHCS_EV_OC_BIT] = s_r.ev_oc;
   end

   // Next-state logic for all command and event bits
   always_comb begin
      s_nxt     = s_r;
      s_nxt.ovr = 1'b0;
      // Track periodic completion within the frame; per_done keeps a
      // completion seen earlier until the frame ends
      if (periodic_done) begin
         s_nxt.per_done = 1'b1;
      end

      // Overrun: periodic work still open at EOF. A completion pulse in
      // the same cycle as EOF still counts as finished in time
      if (frame_eof) begin
         s_nxt.per_done = 1'b0;
         if (!(s_r.per_done || periodic_done)) begin
            s_nxt.ovr   = 1'b1;
            s_nxt.soc   = s_r.soc + 2'h1;
         end
      end

      // Software writes: write 1 sets, 0 leaves. Command bits sit in
      // the low byte, so only that strobe lets them through
      if (wr_acc && hit_cmd && wr_lo) begin
         if (pwdata[UHCS_OCR_BIT]) begin
            s_nxt.ownership_change_request = 1'b1;
         end
         if (pwdata[UHCS_BLF_BIT]) begin
            s_nxt.bulk_list_filled = 1'b1;
         end
         if (pwdata[UHCS_CLF_BIT]) begin
            s_nxt.control_list_filled = 1'b1;
         end
         if (pwdata[UHCS_SRST_BIT]) begin
            s_nxt.srst = 1'b1;
         end
         // Counter bits are not writable
      end

      // Ownership change taken: clear the request
      if (ownership_done && s_r.ownership_change_request) begin
         s_nxt.ownership_change_request = 1'b0;
      end
      // A new request in the same cycle as the change wins over the clear
      if (wr_acc && hit_cmd && wr_lo && pwdata[UHCS_OCR_BIT]) begin
         s_nxt.ownership_change_request = 1'b1;
      end

      // List start clears filled; found TD sets again, set wins.
      // The software set comes last so a new descriptor is never lost
      if (bulk_if.start) begin
         s_nxt.bulk_list_filled = 1'b0;
      end
      if (bulk_if.busy && bulk_if.td_found) begin
         s_nxt.bulk_list_filled = 1'b1;
      end
      if (wr_acc && hit_cmd && wr_lo && pwdata[UHCS_BLF_BIT]) begin
         s_nxt.bulk_list_filled = 1'b1;
      end
      if (ctrl_if.start) begin
         s_nxt.control_list_filled = 1'b0;
      end
      if (ctrl_if.busy && ctrl_if.td_found) begin
         s_nxt.control_list_filled = 1'b1;
      end
      if (wr_acc && hit_cmd && wr_lo && pwdata[UHCS_CLF_BIT]) begin
         s_nxt.control_list_filled = 1'b1;
      end

      // Soft reset finished: clear request and command state. The overrun
      // counter and the event flags survive it; software clears the flags,
      // only the hardware reset clears the counter
      if (srst_done) begin
         s_nxt.srst = 1'b0;
         s_nxt.bulk_list_filled  = 1'b0;
         s_nxt.control_list_filled  = 1'b0;
         s_nxt.ownership_change_request  = 1'b0;
      end

      // Event flags: write 1 clears, hardware set wins
      // Each flag clears only with its own byte strobe
      if (wr_acc && hit_ev && pwdata[UHCS_EV_SO_BIT] && pstrb[0]) begin
         s_nxt.ev_so = 1'b0;
      end
      if (wr_acc && hit_ev && pwdata[UHCS_EV_OC_BIT] && pstrb[3]) begin
         s_nxt.ev_oc = 1'b0;
      end
      if (s_nxt.ovr) begin
         s_nxt.ev_so = 1'b1;
      end
      if (s_r.ownership_change_request) begin
         s_nxt.ev_oc = 1'b1;
      end

      // Read data captured in setup so it stands in the access phase;
      // unmapped words read as a fixed pattern and raise pslverr
      if (rd_acc) begin
         if (hit_cmd) begin
            s_nxt.rdata = cmd_view;
         end else if (hit_ev) begin
            s_nxt.rdata = ev_view;
         end else if (hit_lst) begin
            s_nxt.rdata = {29'h0, srst_act, ctrl_if.busy, bulk_if.busy};
         end else begin
            s_nxt.rdata = UHCS_BAD_ADDR_DATA;
         end
      end
   end

   // Outputs; pslverr is combinational and only has meaning in the
   // access phase, while prdata comes from a flip-flop
   assign prdata  = s_r.rdata;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !(hit_cmd || hit_ev || hit_lst);
   assign bulk_busy              = bulk_if.busy;
   assign ctrl_busy              = ctrl_if.busy;
   assign periodic_overrun       = s_r.ovr;
   assign ownership_change_event = s_r.ev_oc;
   assign soft_reset_active      = srst_act;

   // State register; the counter reset is named on its own so that its
   // value stays visible beside the all-zero reset of the rest
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r     <= '0;
         s_r.soc <= UHCS_SOC_RST;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule : uhcs_cmd_status

// ---- design/uhcs_list_if.sv ----
// Interface joining the main block to its list walkers
`timescale 1ns/10ps
interface uhcs_list_if;
   logic head;     // Walker reached head of list
   logic td_found; // Walker saw a transfer descriptor
   logic pass_end; // Pass over list finished
   logic filled;   // Current filled bit
   logic start;    // Walker starts processing (clears bit)
   logic busy;     // Walker is processing
   modport walker (input head, input td_found, input pass_end,
                   input filled, output start, output busy);
   modport owner  (output head, output td_found, output pass_end,
                   output filled, input start, input busy);
endinterface : uhcs_list_if

// ---- design/uhcs_list_walk.sv ----
// Gate for one async list: waits on filled, clears it on start
`timescale 1ns/10ps
module uhcs_list_walk
   import uhcs_pkg::*;
(
   input  wire logic   pclk,    // System clock
   input  wire logic   presetn, // Async reset, active low
   uhcs_list_if.walker lst      // List handshake
);
   typedef struct packed {
      uhcs_lst_t st; // Walker state
   } uhcs_walk_t;

   uhcs_walk_t s_r;   // Registered state
   uhcs_walk_t s_nxt; // Next state

   // Start only at the head with the filled bit set
   always_comb begin
      s_nxt = s_r;
      case (s_r.st)
         UHCS_L_IDLE: begin
            if (lst.head && lst.filled) begin
               s_nxt.st = UHCS_L_RUN;
            end
         end
         UHCS_L_RUN: begin
            if (lst.pass_end) begin
               s_nxt.st = UHCS_L_DONE;
            end
         end
         default: begin
            s_nxt.st = UHCS_L_IDLE;
         end
      endcase
   end

   // Start pulse clears the filled bit in the owner
   assign lst.start = (s_r.st == UHCS_L_IDLE) && lst.head && lst.filled;
   assign lst.busy  = (s_r.st == UHCS_L_RUN);

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r.st <= UHCS_L_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule : uhcs_list_walk

// ---- design/uhcs_pkg.sv ----
// Package of constants and types for the host command and status block
package uhcs_pkg;
   // Register map (byte offsets)
   localparam logic [11:0] UHCS_CMDSTAT_OFS   = 12'h008; // Command and status
   localparam logic [11:0] UHCS_EVSTAT_OFS    = 12'h00C; // Event status flags
   localparam logic [11:0] UHCS_LISTCTL_OFS   = 12'h010; // List engine status
   // Command and status field positions
   localparam int          UHCS_SRST_BIT      = 0;       // Soft reset request
   localparam int          UHCS_CLF_BIT       = 1;       // Control list filled
   localparam int          UHCS_BLF_BIT       = 2;       // Bulk list filled
   localparam int          UHCS_OCR_BIT       = 3;       // Ownership request
   localparam int          UHCS_SOC_LO        = 16;      // Overrun count low
   localparam int          UHCS_SOC_HI        = 17;      // Overrun count high
   // Event status field positions
   localparam int          UHCS_EV_SO_BIT     = 0;       // Overrun event
   localparam int          UHCS_EV_OC_BIT     = 30;      // Ownership event
   // Reset values
   localparam logic [1:0]  UHCS_SOC_RST       = 2'h0;    // Counter reset
   localparam logic [31:0] UHCS_ZERO          = 32'h0000_0000;
   // Soft reset timing
   localparam int          UHCS_CLK_MHZ       = 100;     // pclk rate
   localparam int          UHCS_SRST_MAX_US   = 10;      // Longest soft reset
   localparam int          UHCS_SRST_CYC      =
      UHCS_SRST_MAX_US * UHCS_CLK_MHZ;                   // Exact, 1000 cycles
   localparam logic [31:0] UHCS_BAD_ADDR_DATA = 32'h0000_0000;
   // List walker states
   typedef enum logic [1:0] {
      UHCS_L_IDLE = 2'b00,   // Waiting at list head
      UHCS_L_RUN  = 2'b01,   // Walking the list
      UHCS_L_DONE = 2'b10    // List finished this pass
   } uhcs_lst_t;
endpackage : uhcs_pkg

// ---- design/uhcs_srst_timer.sv ----
// Soft reset sequencer, bounded to the longest allowed time
`timescale 1ns/10ps
module uhcs_srst_timer
   import uhcs_pkg::*;
#(
   parameter int SRST_CYC = UHCS_SRST_CYC // Cycles the reset takes
)(
   input  wire logic pclk,     // System clock
   input  wire logic presetn,  // Async reset, active low
   input  wire logic req,      // Soft reset requested
   output logic      active,   // Soft reset in progress
   output logic      done      // One-cycle completion pulse
);
   // Below three cycles the countdown would underflow
   if (SRST_CYC < 3 || SRST_CYC > UHCS_SRST_CYC) begin : g_bad_cyc
      $error("SRST_CYC out of range");
   end

   typedef struct packed {
      logic [15:0] cnt; // Remaining cycles
      logic        act; // Running
      logic        dn;  // Done pulse
   } uhcs_tmr_t;

   uhcs_tmr_t t_r;   // Registered state
   uhcs_tmr_t t_nxt; // Next state

   // Count down; done comes in the last of the SRST_CYC cycles the request bit stands
   always_comb begin
      t_nxt    = t_r;
      t_nxt.dn = 1'b0;
      if (t_r.act) begin
         if (t_r.cnt == 16'h0000) begin
            t_nxt.act = 1'b0;
            t_nxt.dn  = 1'b1;
         end else begin
            t_nxt.cnt = t_r.cnt - 16'h0001;
         end
      end else if (req && !t_r.dn) begin
         t_nxt.act = 1'b1;
         // Request bit then stands exactly SRST_CYC cycles
         t_nxt.cnt = 16'(SRST_CYC - 3);
      end
   end

   assign active = t_r.act;
   assign done   = t_r.dn;

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t_r <= '0;
      end else begin
         t_r <= t_nxt;
      end
   end
endmodule : uhcs_srst_timer

// ---- dv/uhcs_cmd_status_bench.sv ----
// Self-checking bench of the command and status block
`timescale 1ns/10ps
module uhcs_cmd_status_bench
   import uhcs_pkg::*;
;
   localparam int SRST = 4; // Short soft reset keeps the run brief
   typedef struct {
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] q;
      logic        e;
   } uhcs_row_t;
   // Write then read back; last row is an unmapped place
   uhcs_row_t rows [4] = '{
      '{12'h008, 32'h0000_0004, 32'h0000_0004, 1'b0},
      '{12'h008, 32'h0000_0000, 32'h0000_0004, 1'b0},
      '{12'h008, 32'h0003_0002, 32'h0000_0006, 1'b0},
      '{12'h0FC, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;    // Address
   logic [31:0] pwdata;   // Write data
   logic [31:0] prdata;   // Read data
   logic [31:0] rd;       // Last read word
   logic [3:0]  pstrb;    // Strobes
   logic [6:0]  pu;       // Pulse inputs
   logic [1:0]  hd;       // List heads: 0 bulk, 1 control
   logic        bbusy, cbusy, ovr, oce, sra;
   int          num_errors, n_tests, ovr_seen, cyc;
   uhcs_cmd_status #(.SRST_CYC(SRST)) uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .frame_eof(pu[0]), .periodic_done(pu[1]),
      .ownership_done(pu[2]), .bulk_head(hd[0]), .bulk_td(pu[3]),
      .bulk_end(pu[4]), .ctrl_head(hd[1]), .ctrl_td(pu[5]),
      .ctrl_end(pu[6]), .bulk_busy(bbusy), .ctrl_busy(cbusy),
      .periodic_overrun(ovr), .ownership_change_event(oce),
      .soft_reset_active(sra));
   // Clock, 10 ns period
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Overrun pulses and hang guard
   always @(posedge pclk) begin
      cyc++;
      if (ovr === 1'b1) ovr_seen++;
      if (cyc == 4000) begin
         num_errors++;
         complete_run();
      end
   end
   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_tests++;
      if (g !== x) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
         num_errors++;
      end
   endtask : chk
   // One transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for pready however long; only the bench timeout ends a hang
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(rd, x);
   endtask : rdc
   task automatic pulse(input int b);
      @(posedge pclk);
      pu[b] <= 1'b1;
      @(posedge pclk);
      pu[b] <= 1'b0;
   endtask : pulse
   function automatic logic busy(input int c);
      return c ? cbusy : bbusy;
   endfunction : busy
   // One pass over a list, optionally finding a descriptor
   task automatic walk(input int c, input logic td);
      hd[c] <= 1'b1;
      for (int k = 0; k < 20 && busy(c) !== 1'b1; k++) @(posedge pclk);
      hd[c] <= 1'b0;
      chk(32'(busy(c)), 32'h1);
      rdc(UHCS_LISTCTL_OFS, 32'(1 << c));
      apb(1'b0, UHCS_CMDSTAT_OFS, 32'h0);
      chk(32'(rd[2 - c]), 32'h0);
      if (td) pulse(3 + 2 * c);
      pulse(4 + 2 * c);
      repeat (3) @(posedge pclk);
      chk(32'(busy(c)), 32'h0);
      apb(1'b0, UHCS_CMDSTAT_OFS, 32'h0);
      chk(32'(rd[2 - c]), 32'(td));
      // Empty list must not start
      if (!td) begin
         hd[c] <= 1'b1;
         repeat (8) @(posedge pclk);
         chk(32'(busy(c)), 32'h0);
         hd[c] <= 1'b0;
      end
   endtask : walk
   initial begin
      int k;
      {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {pu, hd} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      pstrb <= 4'hF;
      rdc(UHCS_CMDSTAT_OFS, 32'h0);
      rdc(UHCS_EVSTAT_OFS, 32'h0);
      $display("test reset done");
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0);
         chk(rd, rows[i].q);
         chk(32'(err), 32'(rows[i].e));
      end
      $display("test table done");
      apb(1'b1, UHCS_CMDSTAT_OFS, 32'h0000_0008);
      repeat (2) @(posedge pclk);
      chk(32'(oce), 32'h1);
      rdc(UHCS_CMDSTAT_OFS, 32'h0000_000E);
      pulse(2);
      rdc(UHCS_CMDSTAT_OFS, 32'h0000_0006);
      chk(32'(oce), 32'h1);
      apb(1'b1, UHCS_EVSTAT_OFS, 32'h4000_0000);
      rdc(UHCS_EVSTAT_OFS, 32'h0);
      $display("test ownership done");
      pulse(1);
      pulse(0);
      repeat (5) begin
         pulse(0);
         repeat (2) @(posedge pclk);
      end
      chk(ovr_seen, 32'd5);
      rdc(UHCS_CMDSTAT_OFS, 32'h0001_0006);
      rdc(UHCS_EVSTAT_OFS, 32'h0000_0001);
      apb(1'b1, UHCS_EVSTAT_OFS, 32'h0000_0001);
      rdc(UHCS_EVSTAT_OFS, 32'h0);
      $display("test overrun done");
      walk(0, 1'b1);
      walk(0, 1'b0);
      walk(1, 1'b1);
      walk(1, 1'b0);
      $display("test lists done");
      apb(1'b1, UHCS_CMDSTAT_OFS, 32'h0000_0007);
      for (k = 0; k < 40 && sra !== 1'b1; k++) @(posedge pclk);
      for (k = 0; k < 40 && sra === 1'b1; k++) @(posedge pclk);
      chk(32'(k < SRST), 32'h1);
      rdc(UHCS_CMDSTAT_OFS, 32'h0001_0000);
      $display("test soft reset done");
      // Mid-run reset with a raised flag and a counter away from zero
      apb(1'b1, UHCS_CMDSTAT_OFS, 32'h0000_0008);
      repeat (2) @(posedge pclk);
      chk(32'(oce), 32'h1);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(32'(oce), 32'h0);
      presetn <= 1'b1;
      rdc(UHCS_CMDSTAT_OFS, 32'h0);
      rdc(UHCS_EVSTAT_OFS, 32'h0);
      $display("test mid reset done");
      complete_run();
   end
endmodule : uhcs_cmd_status_bench

// ---- dv/uhcs_cmd_status_properties.sv ----
// Port checker of the command and status block, bound to its top
`timescale 1ns/10ps
module uhcs_chk
   import uhcs_pkg::*;
#(
   parameter int SRST_CYC = UHCS_SRST_CYC // Soft reset length
)(
   input wire logic        pclk,                   // Clock
   input wire logic        presetn,                // Reset, active low
   input wire logic        psel,                   // Select
   input wire logic        penable,                // Access phase
   input wire logic        pwrite,                 // Write
   input wire logic [11:0] paddr,                  // Address
   input wire logic [31:0] pwdata,                 // Write data
   input wire logic [3:0]  pstrb,                  // Strobes
   input wire logic [31:0] prdata,                 // Read data
   input wire logic        pready,                 // Ready
   input wire logic        frame_eof,              // Frame end
   input wire logic        bulk_head,              // Bulk at head
   input wire logic        bulk_end,               // Bulk pass end
   input wire logic        bulk_busy,              // Bulk running
   input wire logic        ctrl_head,              // Control at head
   input wire logic        ctrl_end,               // Control pass end
   input wire logic        ctrl_busy,              // Control running
   input wire logic        periodic_overrun,       // Overrun pulse
   input wire logic        ownership_change_event, // Ownership flag
   input wire logic        soft_reset_active       // Soft reset running
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Software clear of the ownership flag
   wire ev_clr = psel && penable && pwrite && paddr == UHCS_EVSTAT_OFS &&
                 pwdata[UHCS_EV_OC_BIT] && pstrb[3];
   // Length of the running soft reset; a hang would grow it without end
   logic [15:0] srst_cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) srst_cnt_r <= 16'h0;
      else srst_cnt_r <= soft_reset_active ? srst_cnt_r + 16'h1 : 16'h0;
   end
   sequence s_rd_cmd;
      psel && !penable && !pwrite && paddr == UHCS_CMDSTAT_OFS;
   endsequence
   sequence s_bulk_go;
      !bulk_busy ##1 bulk_busy;
   endsequence
   sequence s_ctrl_go;
      !ctrl_busy ##1 ctrl_busy;
   endsequence
   property p_rdy; pready; endproperty
   property p_rsv;
      s_rd_cmd |=> prdata[31:18] == 14'h0 && prdata[15:4] == 12'h0;
   endproperty
   property p_ovr_cause;
      periodic_overrun |-> $past(frame_eof) || $past(frame_eof, 2);
   endproperty
   property p_ovr_pulse; periodic_overrun |=> !periodic_overrun; endproperty
   property p_oc_hold;
      ownership_change_event && !ev_clr |=> ownership_change_event;
   endproperty
   property p_bulk_gate; s_bulk_go |-> $past(bulk_head); endproperty
   property p_ctrl_gate; s_ctrl_go |-> $past(ctrl_head); endproperty
   property p_bulk_end; bulk_busy && bulk_end |-> ##[1:2] !bulk_busy;
   endproperty
   property p_ctrl_end; ctrl_busy && ctrl_end |-> ##[1:2] !ctrl_busy;
   endproperty
   property p_srst; srst_cnt_r < SRST_CYC - 1; endproperty
   a_rdy: assert property (p_rdy) else $error("pready low");
   a_rsv: assert property (p_rsv) else $error("reserved bit set");
   a_ovr_cause: assert property (p_ovr_cause) else $error("stray ovr");
   a_ovr_pulse: assert property (p_ovr_pulse) else $error("ovr long");
   a_oc_hold: assert property (p_oc_hold) else $error("flag lost");
   a_bulk_gate: assert property (p_bulk_gate) else $error("bulk go");
   a_ctrl_gate: assert property (p_ctrl_gate) else $error("ctrl go");
   a_bulk_end: assert property (p_bulk_end) else $error("bulk hang");
   a_ctrl_end: assert property (p_ctrl_end) else $error("ctrl hang");
   a_srst: assert property (p_srst) else $error("soft reset long");
endmodule : uhcs_chk
bind uhcs_cmd_status uhcs_chk #(.SRST_CYC(SRST_CYC)) u_chk (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
   .frame_eof, .bulk_head, .bulk_end, .bulk_busy, .ctrl_head, .ctrl_end,
   .ctrl_busy, .periodic_overrun, .ownership_change_event,
   .soft_reset_active);
